// ==== src/opkl_map.svh ====
`ifndef OPKL_MAP_SVH
`define OPKL_MAP_SVH

// ----------------------------------------------------------------
// Register map (word addresses on the plain port)
// ----------------------------------------------------------------
// Shared map of last used panel: words 0..2
`define OPKL_A_LAST_MAP      8'h00
// Global inhibit: words 3..5
`define OPKL_A_GLB_INH       8'h03
// Global lamps: words 6..7
`define OPKL_A_GLB_LAMP      8'h06
// Status: presence mask, last panel, override results
`define OPKL_A_STATUS        8'h08
`define OPKL_A_OVR           8'h09
// Per-panel block base and stride
`define OPKL_A_PANEL_BASE    8'h10
`define OPKL_PANEL_STRIDE    8'h10
// Offsets inside a panel block
`define OPKL_P_MAP           4'h0
`define OPKL_P_INH           4'h4
`define OPKL_P_LAMP          4'h8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OPKL_JOG1_BIT        16
`define OPKL_USER1_BIT       0
// Override position fields live in inhibit word 3 (panel offset 7 / global address 9)
`define OPKL_FEED_LSB        0
`define OPKL_SPIN_LSB        16

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define OPKL_RST_WORD        32'h0000_0000

`endif

// ==== src/opkl_pkg.sv ====
package opkl_pkg;

    typedef logic [31:0] opkl_word_type;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } opkl_bus_req_type;

    // Key words per panel: three map words
    typedef struct packed {
        opkl_word_type [2:0] map;
    } opkl_keys_type;

    // Selector positions of the feed and spindle override switches, one-hot per position
    typedef struct packed {
        logic [15:0] feed_pos;
        logic [15:0] spin_pos;
    } opkl_ovr_sel_type;

endpackage

// ==== src/opkl_panel_regs.sv ====
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "opkl_map.svh"

module opkl_panel_regs
    import opkl_pkg::*;
#(
    parameter int NPANEL = 8
)(
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_reset,
    // Register port
    input  wire logic [7:0]              i_addr,
    input  wire logic [31:0]             i_wdata,
    input  wire logic                    i_wr,
    input  wire logic                    i_rd,
    output logic [31:0]                  o_rdata,
    // Panel side
    input  wire logic [NPANEL-1:0]       i_panel_present,
    input  wire opkl_keys_type [NPANEL-1:0] i_panel_keys,
    input  wire opkl_ovr_sel_type [NPANEL-1:0] i_panel_ovr,
    output opkl_keys_type [NPANEL-1:0]   o_key_action,
    output opkl_word_type [NPANEL-1:0]   o_lamp1,
    output opkl_word_type [NPANEL-1:0]   o_lamp2,
    output logic [4:0]                   o_feed_pos,
    output logic                         o_feed_zero,
    output logic [4:0]                   o_spin_pos
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    opkl_word_type [2:0]        last_map_q;
    opkl_word_type [2:0]        last_map_d;
    logic [2:0]                 last_idx_q;
    logic [2:0]                 last_idx_d;
    opkl_word_type [3:0]        glb_inh_q;
    opkl_word_type [1:0]        glb_lamp_q;
    opkl_word_type [NPANEL-1:0][3:0] pan_inh_q;
    opkl_word_type [NPANEL-1:0][1:0] pan_lamp_q;
    opkl_keys_type [NPANEL-1:0] keys_prev_q;
    logic [4:0]                 spin_pos_q;
    logic [4:0]                 spin_pos_d;
    logic [4:0]                 feed_pos_d;
    logic                       feed_zero_d;
    logic [31:0]                rdata_d;
    opkl_keys_type [NPANEL-1:0] key_action_d;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [4:0] lowest_set(input logic [15:0] v);
        logic [4:0] r;
        r = 5'h10;
        for (int k = 15; k >= 0; k--)
        begin
            if (v[k])
            begin
                r = 5'(k);
            end
        end
        return r;
    endfunction

    // Position index of a one-hot selector, 16 when none
    function automatic logic [4:0] sel_index(input logic [15:0] v);
        return lowest_set(v);
    endfunction

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire        a_panel    = i_addr >= `OPKL_A_PANEL_BASE;
    wire [3:0]  a_pidx     = 4'(( i_addr - `OPKL_A_PANEL_BASE) >> 4);
    wire [3:0]  a_off      = i_addr[3:0];
    wire        a_pvalid   = a_panel && (32'(a_pidx) < NPANEL);
    wire [2:0]  a_p        = a_pidx[2:0];

    // ------------------------------------------------------------
    // Word and write decode
    // ------------------------------------------------------------
    wire        a_map_off   = a_off < 4'h3;
    wire        a_inh_off   = (a_off >= `OPKL_P_INH) && (a_off < `OPKL_P_INH + 4'h4);
    wire        a_lamp_off  = (a_off >= `OPKL_P_LAMP) && (a_off < `OPKL_P_LAMP + 4'h2);
    wire [1:0]  glb_inh_idx = 2'(i_addr - `OPKL_A_GLB_INH);
    wire        wr_glb_inh  = i_wr && (i_addr >= `OPKL_A_GLB_INH) && (i_addr < `OPKL_A_GLB_LAMP);
    wire        wr_glb_lamp = i_wr && (i_addr[7:1] == 7'(`OPKL_A_GLB_LAMP >> 1));
    wire        wr_ovr      = i_wr && (i_addr == `OPKL_A_OVR);
    wire        wr_pan_inh  = i_wr && a_pvalid && a_inh_off;
    wire        wr_pan_lamp = i_wr && a_pvalid && a_lamp_off;

    // ------------------------------------------------------------
    // Last used panel tracking
    // ------------------------------------------------------------
    // Lowest-numbered panel with a new press wins a same-cycle tie
    always_comb
    begin
        last_idx_d = last_idx_q;
        for (int p = NPANEL - 1; p >= 0; p--)
        begin
            if (i_panel_present[p] && (i_panel_keys[p] & ~keys_prev_q[p]) != '0)
            begin
                last_idx_d = 3'(p);
            end
        end
        if (i_panel_present == NPANEL'(1))
        begin
            last_idx_d = 3'h0;
        end
        last_map_d = i_panel_keys[last_idx_d].map;
    end

    // ------------------------------------------------------------
    // Inhibit and actions
    // ------------------------------------------------------------
    always_comb
    begin
        for (int p = 0; p < NPANEL; p++)
        begin
            for (int w = 0; w < 3; w++)
            begin
                key_action_d[p].map[w] = i_panel_keys[p].map[w]
                    & ~glb_inh_q[w] & ~pan_inh_q[p][w]
                    & {32{i_panel_present[p]}};
            end
        end
    end

    // ------------------------------------------------------------
    // Override resolution on the last used panel
    // ------------------------------------------------------------
    wire [15:0] feed_ok  = ~(glb_inh_q[3][`OPKL_FEED_LSB +: 16]
                           | pan_inh_q[last_idx_q][3][`OPKL_FEED_LSB +: 16]);
    wire [15:0] spin_ok  = ~(glb_inh_q[3][`OPKL_SPIN_LSB +: 16]
                           | pan_inh_q[last_idx_q][3][`OPKL_SPIN_LSB +: 16]);
    wire [4:0]  feed_sel = sel_index(i_panel_ovr[last_idx_q].feed_pos);
    wire [4:0]  spin_sel = sel_index(i_panel_ovr[last_idx_q].spin_pos);

    always_comb
    begin
        feed_pos_d  = feed_sel;
        feed_zero_d = 1'b0;
        spin_pos_d  = spin_sel;
        if (feed_sel < 5'h10 && !feed_ok[feed_sel[3:0]])
        begin
            feed_pos_d  = lowest_set(feed_ok);
            feed_zero_d = (feed_ok == 16'h0000);
        end
        if (spin_sel < 5'h10 && !spin_ok[spin_sel[3:0]])
        begin
            spin_pos_d = (spin_ok == 16'h0000) ? spin_pos_q : lowest_set(spin_ok);
        end
        if (spin_sel == 5'h10)
        begin
            spin_pos_d = spin_pos_q;
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb
    begin
        rdata_d = `OPKL_RST_WORD;
        if (!a_panel)
        begin
            case (i_addr)
                8'h00, 8'h01, 8'h02: rdata_d = last_map_q[i_addr[1:0]];
                8'h03, 8'h04, 8'h05: rdata_d = glb_inh_q[2'(i_addr - `OPKL_A_GLB_INH)];
                8'h07:               rdata_d = glb_lamp_q[1];
                8'h06:               rdata_d = glb_lamp_q[0];
                8'h08:               rdata_d = {21'h0, last_idx_q, 8'(i_panel_present)};
                8'h09:               rdata_d = {16'h0, 3'h0, spin_pos_q, 2'h0, o_feed_zero,
                                                o_feed_pos};
                default:             rdata_d = `OPKL_RST_WORD;
            endcase
        end
        else if (a_pvalid)
        begin
            if (a_map_off)
            begin
                rdata_d = i_panel_keys[a_p].map[a_off[1:0]];
            end
            else if (a_inh_off)
            begin
                rdata_d = pan_inh_q[a_p][a_off[1:0]];
            end
            else if (a_lamp_off)
            begin
                rdata_d = pan_lamp_q[a_p][a_off[0]];
            end
        end
    end

    // ------------------------------------------------------------
    // Last used panel registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            last_map_q  <= '0;
            last_idx_q  <= 3'h0;
            keys_prev_q <= '0;
        end
        else
        begin
            last_map_q  <= last_map_d;
            last_idx_q  <= last_idx_d;
            keys_prev_q <= i_panel_keys;
        end
    end

    // ------------------------------------------------------------
    // Global inhibit and lamp words
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            glb_inh_q  <= '0;
            glb_lamp_q <= '0;
        end
        else
        begin
            if (wr_glb_inh)
            begin
                glb_inh_q[glb_inh_idx] <= i_wdata;
            end
            // Override inhibit word shared by all panels
            if (wr_ovr)
            begin
                glb_inh_q[3] <= i_wdata;
            end
            if (wr_glb_lamp)
            begin
                glb_lamp_q[i_addr[0]] <= i_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Per-panel inhibit and lamp words
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            pan_inh_q  <= '0;
            pan_lamp_q <= '0;
        end
        else
        begin
            if (wr_pan_inh)
            begin
                pan_inh_q[a_p][a_off[1:0]] <= i_wdata;
            end
            if (wr_pan_lamp)
            begin
                pan_lamp_q[a_p][a_off[0]] <= i_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Override results and read data
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            spin_pos_q  <= 5'h10;
            o_feed_pos  <= 5'h10;
            o_feed_zero <= 1'b0;
            o_rdata     <= `OPKL_RST_WORD;
        end
        else
        begin
            spin_pos_q  <= spin_pos_d;
            o_feed_pos  <= feed_pos_d;
            o_feed_zero <= feed_zero_d;
            // Zero outside the answer cycle keeps stale data off the port
            o_rdata     <= i_rd ? rdata_d : `OPKL_RST_WORD;
        end
    end

    // ------------------------------------------------------------
    // Key actions
    // ------------------------------------------------------------
    // One cycle behind the keys, the price of a flop-fed output
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            o_key_action <= '0;
        end
        else
        begin
            o_key_action <= key_action_d;
        end
    end

    // ------------------------------------------------------------
    // Lamp outputs
    // ------------------------------------------------------------
    // Registered copy keeps every output straight from a flop
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            o_lamp1 <= '0;
            o_lamp2 <= '0;
        end
        else
        begin
            for (int p = 0; p < NPANEL; p++)
            begin
                o_lamp1[p] <= glb_lamp_q[0] | pan_lamp_q[p][0];
                o_lamp2[p] <= glb_lamp_q[1] | pan_lamp_q[p][1];
            end
        end
    end

    assign o_spin_pos = spin_pos_q;

endmodule
`default_nettype wire

// ==== bench/opkl_panel_regs_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module opkl_chk
    import opkl_pkg::*;
#(
    parameter int NPANEL = 8
)(
    input wire logic                       i_clk_sys,
    input wire logic                       i_reset,
    input wire logic [7:0]                 i_addr,
    input wire logic [31:0]                i_wdata,
    input wire logic                       i_wr,
    input wire logic                       i_rd,
    input wire logic [31:0]                o_rdata,
    input wire logic [NPANEL-1:0]          i_panel_present,
    input wire opkl_keys_type [NPANEL-1:0] i_panel_keys,
    input wire opkl_keys_type [NPANEL-1:0] o_key_action,
    input wire opkl_word_type [NPANEL-1:0] o_lamp1,
    input wire logic                       o_feed_zero,
    input wire logic [4:0]                 o_feed_pos,
    input wire logic [4:0]                 o_spin_pos
);
    // ------------------------------------------------------------
    // Port checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    wire logic [31:0] k0;
    assign k0 = i_panel_keys[0].map[0];
    logic [31:0] glb_w0_q;

    // Shadow of the first global inhibit word, snooped from the bus
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            glb_w0_q <= 32'h0000_0000;
        end
        else if (i_wr && i_addr == 8'h03)
        begin
            glb_w0_q <= i_wdata;
        end
    end

    // Actions are registered, so they follow the keys one cycle late
    AST_ACT_INH: assert property (
        (o_key_action[0].map[0] & ~$past(k0)) == 32'h0000_0000)
        else $error("action on a key not pressed");
    AST_GLB_INH: assert property (
        (o_key_action[0].map[0] & $past(glb_w0_q)) == 32'h0000_0000)
        else $error("action on a globally inhibited key");
    // Keys held steady so a registered mirror has caught up
    AST_LAST_ONE: assert property ((i_panel_present == NPANEL'(1) && $stable(k0))[*3]
        ##0 (i_rd && i_addr == 8'h00) |=> o_rdata == $past(k0)) else $error("shared map off");
    AST_PANEL_MAP: assert property ($stable(k0)[*2] ##0 (i_rd && i_addr == 8'h10)
        |=> o_rdata == $past(k0)) else $error("panel map read off");
    AST_INH_RB: assert property ((i_wr && i_addr == 8'h03) ##1 !i_wr ##1
        (i_rd && i_addr == 8'h03) |=> o_rdata == $past(i_wdata, 3)) else $error("inhibit readback");
    AST_LAMP_GLB: assert property ((i_wr && i_addr == 8'h06) |-> ##2
        (o_lamp1[1] & $past(i_wdata, 2)) == $past(i_wdata, 2)) else $error("global lamp");
    AST_LAMP_PNL: assert property ((i_wr && i_addr == 8'h18) |-> ##2
        (o_lamp1[0] & $past(i_wdata, 2)) == $past(i_wdata, 2)) else $error("panel lamp");
    AST_FEED_ZERO: assert property (o_feed_zero |-> o_feed_pos == 5'h10)
        else $error("zero feed with a position");
    // Spindle never falls back to no position once running
    AST_SPIN_HOLD: assert property (!$stable(o_spin_pos) |-> o_spin_pos < 5'h10)
        else $error("spindle position dropped");

    cover property (o_feed_zero);
    cover property (o_spin_pos < 5'h10);
    cover property (o_key_action[1].map[0] != 32'h0000_0000);
endmodule

bind opkl_panel_regs opkl_chk #(.NPANEL(NPANEL)) u_chk (
    .i_clk_sys, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_panel_present, .i_panel_keys, .o_key_action, .o_lamp1,
    .o_feed_zero, .o_feed_pos, .o_spin_pos
);
`default_nettype wire

// ==== bench/opkl_panel_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module opkl_panel_model
    import opkl_pkg::*;
#(
    parameter int NPANEL = 2
)(
    input  wire logic                         i_clk_sys,
    output var opkl_keys_type [NPANEL-1:0]    o_keys,
    output var opkl_ovr_sel_type [NPANEL-1:0] o_ovr,
    output var logic [NPANEL-1:0]             o_present
);
    // ------------------------------------------------------------
    // Keyboards: levels change only after a clock edge
    // ------------------------------------------------------------
    initial
    begin
        o_keys = '0;
        o_ovr = '0;
        o_present = '1;
    end

    task automatic press(input int p, input opkl_word_type w);
        @(posedge i_clk_sys);
        o_keys[p].map[0] <= w;
    endtask

    task automatic presence(input logic [NPANEL-1:0] v);
        @(posedge i_clk_sys);
        o_present <= v;
    endtask

    task automatic sel(input int p, input logic [15:0] f, input logic [15:0] s);
        @(posedge i_clk_sys);
        o_ovr[p] <= '{f, s};
    endtask
endmodule
`default_nettype wire

// ==== bench/tb_operator_panel_key_led_registers.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_operator_panel_key_led_registers;
    import opkl_pkg::*;
    localparam int NP = 2;
    logic                      clk = 1'b0;
    logic                      rst = 1'b1;
    logic [7:0]                addr = 8'h00;
    logic [31:0]               wdata = 32'h0000_0000;
    logic                      wr = 1'b0;
    logic                      rd = 1'b0;
    logic [31:0]               rdata;
    logic [NP-1:0]             pres;
    opkl_keys_type [NP-1:0]    keys;
    opkl_keys_type [NP-1:0]    act;
    opkl_ovr_sel_type [NP-1:0] ovr;
    opkl_word_type [NP-1:0]    lamp1;
    opkl_word_type [NP-1:0]    lamp2;
    logic [4:0]                fpos;
    logic [4:0]                spos;
    logic                      fzero;
    int                        miscompares = 0;
    int                        comparisons = 0;
    int                        cycles = 0;

    opkl_panel_regs #(.NPANEL(NP)) u_dut (
        .i_clk_sys(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_panel_present(pres), .i_panel_keys(keys),
        .i_panel_ovr(ovr), .o_key_action(act), .o_lamp1(lamp1), .o_lamp2(lamp2),
        .o_feed_pos(fpos), .o_feed_zero(fzero), .o_spin_pos(spos));
    opkl_panel_model #(.NPANEL(NP)) u_pnl (
        .i_clk_sys(clk), .o_keys(keys), .o_ovr(ovr), .o_present(pres));

    // ------------------------------------------------------------
    // Clock, hang guard and bus tasks
    // ------------------------------------------------------------
    initial
    begin
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rreg(input logic [7:0] a, input logic [31:0] exp, input string n);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(n, rdata, exp);
    endtask

    task automatic s_regs;
        rreg(8'h03, 32'h0000_0000, "glb inh reset");
        wreg(8'h03, 32'h00A5_0F0F);
        rreg(8'h03, 32'h00A5_0F0F, "glb inh");
        wreg(8'h24, 32'h0001_0000);
        rreg(8'h24, 32'h0001_0000, "inh p2");
        rreg(8'h14, 32'h0000_0000, "inh p1");
        wreg(8'h20, 32'hFFFF_FFFF);
        rreg(8'h20, 32'h0000_0000, "map p2 ro");
        rreg(8'h0A, 32'h0000_0000, "unmapped");
        wreg(8'h03, 32'h0000_0000);
    endtask

    task automatic s_keys;
        u_pnl.press(1, 32'h0000_0001);
        rreg(8'h20, 32'h0000_0001, "map p2");
        rreg(8'h10, 32'h0000_0000, "map p1");
        rreg(8'h00, 32'h0000_0001, "last map p2");
        rreg(8'h08, 32'h0000_0103, "status");
        u_pnl.press(0, 32'h0000_0020);
        rreg(8'h00, 32'h0000_0020, "last map p1");
        u_pnl.presence(2'b01);
        u_pnl.press(0, 32'h0001_0020);
        rreg(8'h00, 32'h0001_0020, "single map");
        rreg(8'h00, 32'h0001_0020, "single map hold");
        u_pnl.presence(2'b11);
    endtask

    task automatic s_inh;
        u_pnl.press(1, 32'h0001_0001);
        repeat (2) @(negedge clk);
        chk("act p2", act[1].map[0], 32'h0000_0001);
        chk("act p1", act[0].map[0], 32'h0001_0020);
        wreg(8'h03, 32'h0000_0020);
        repeat (2) @(negedge clk);
        chk("act p1 glb", act[0].map[0], 32'h0001_0000);
        wreg(8'h03, 32'h0000_0000);
        wreg(8'h24, 32'h0000_0000);
    endtask

    task automatic s_lamp;
        wreg(8'h06, 32'h0000_0001);
        wreg(8'h18, 32'h0000_0100);
        wreg(8'h29, 32'h8000_0000);
        repeat (2) @(negedge clk);
        chk("lamp1 p1", lamp1[0], 32'h0000_0101);
        chk("lamp1 p2", lamp1[1], 32'h0000_0001);
        chk("lamp2 p2", lamp2[1], 32'h8000_0000);
        chk("lamp2 p1", lamp2[0], 32'h0000_0000);
    endtask

    // Panel two was used last, so its selectors and inhibits rule
    task automatic s_ovr;
        u_pnl.sel(1, 16'h0008, 16'h0004);
        wreg(8'h27, 32'h0005_FE7F);
        rreg(8'h09, 32'h0000_0107, "ovr lowest");
        chk("spin lowest", 32'(spos), 32'h0000_0001);
        chk("feed lowest", 32'(fpos), 32'h0000_0007);
        wreg(8'h27, 32'hFFFF_FFFF);
        rreg(8'h09, 32'h0000_0130, "ovr none");
        chk("feed zero", 32'(fzero), 32'h0000_0001);
        wreg(8'h27, 32'h0000_0000);
        wreg(8'h09, 32'h0000_0008);
        rreg(8'h09, 32'h0000_0200, "ovr global");
    endtask

    task automatic end_of_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        s_regs();
        s_keys();
        s_inh();
        s_lamp();
        s_ovr();
        end_of_test();
    end
endmodule
`default_nettype wire
